// [rtl/ddrb2_pkg.sv]
// Shared constants for the burst-of-two separate-I/O static RAM port.
package ddrb2_pkg;
  localparam int          LANE_W      = 9;
  localparam int          BURST_LEN   = 2;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          DATA_W_DEF  = 18;
  localparam int          ADDR_W_DEF  = 6;
  localparam logic        PHASE_K     = 1'b0;
  localparam logic        PHASE_KN    = 1'b1;
  localparam logic        RW_READ     = 1'b1;
  localparam logic        OE_ON_N     = 1'b0;
  localparam logic        OE_OFF_N    = 1'b1;
  localparam int unsigned LOCK_CYCLES = 2048;
  typedef enum logic [1:0] {
    OUT_IDLE   = 2'b01,
    OUT_SECOND = 2'b10
  } ddrb2_out_t;
endpackage

// [rtl/ddrb2_sram_port.sv]
// Command, write and read pipelines of the burst-of-two RAM, plus its read-data FIFO.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ddrb2_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  // Level is counted, not derived from the pointers, so a full store needs no spare slot.
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = level < LW'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = store[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      level <= level + LW'(push) - LW'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) store[wr_ptr] <= in_data;
  end
endmodule // ddrb2_fifo

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RQ1: Address, load strobe and read/write select are sampled on each true-clock rise.
// RQ2: Load strobe high means deselect: no read, no write.
// RQ3: Load low with select high starts a two-beat read at the address; here no read starts while cmd_stall is high.
// RQ4: Read beats are driven only after the following true-clock rise.
// RQ5: First beat on complementary output clock rise, or complementary input rise.
// RQ6: Second beat follows the first on the very next edge.
// RQ7: Read at n gives beats at n plus one and a half and n plus two.
// RQ8: Load low with select low starts a two-beat write at the address.
// RQ9: Write beats are taken at true rise n+1 and complementary rise n+1.5.
// RQ10: Lane masks are sampled with the write beat they qualify.
// RQ11: A high lane mask leaves that nine-bit lane unchanged.
// RQ12: Any mask pattern per beat is accepted; all masked is a no-op.
// RQ13: One write address takes both beats in a single array update.
// RQ14: At eighteen bits wide, each address holds thirty-six bits.
// RQ15: Masking works on nine-bit lanes, on any beat.
// RQ16: At thirty-six bits, four masks gate lanes in ascending order.
// RQ17: With output clocks in use, launch waits for their rising edge.
// RQ18: With output clocks tied high, input clocks time the outputs.
// RQ19: A read or a write may be issued every cycle, no alternation needed; here reads are dropped while cmd_stall is high.
// RQ20: Alternating reads and writes leaves each data port idle half the time.
// RQ21: Controller waits 2048 stable clock cycles before the first command.
// RQ22: Read outputs are not driven in deselect or write slots.
// RQ23: A read right after a write to one address sees the new data.
module ddrb2_sram_port #(
  parameter int DATA_W = ddrb2_pkg::DATA_W_DEF,
  parameter int ADDR_W = ddrb2_pkg::ADDR_W_DEF
) (
  // Clock and reset; edges alternate true-clock rise and complementary rise.
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // Command pins.
  input  wire logic [ADDR_W-1:0] sync_addr_bus,
  input  wire logic              load_n,
  input  wire logic              rw_sel,
  // Write data pins.
  input  wire logic [DATA_W-1:0] write_bus,
  input  wire logic [DATA_W/ddrb2_pkg::LANE_W-1:0] lane_mask_n,
  // Output clock control.
  input  wire logic              oclk_tied_high,
  input  wire logic              oclk_n_rise,
  // Read data pins.
  output logic [DATA_W-1:0]      read_bus,
  output logic                   read_bus_oe_n,
  // Status.
  output logic                   k_phase,
  output logic                   cmd_stall
);
  localparam int LANES = DATA_W / ddrb2_pkg::LANE_W;
  localparam int WORD  = DATA_W * ddrb2_pkg::BURST_LEN;
  localparam int LVL_W = $clog2(ddrb2_pkg::FIFO_DEPTH + 1);

  logic [WORD-1:0]   mem [2**ADDR_W];
  logic              rd_pend;
  logic [ADDR_W-1:0] rd_addr;
  logic              wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic              wr_go;
  logic [ADDR_W-1:0] wr_commit_addr;
  logic [DATA_W-1:0] beat0_data;
  logic [LANES-1:0]  beat0_mask_n;
  logic [DATA_W-1:0] beat1_hold;
  ddrb2_pkg::ddrb2_out_t out_state;
  logic [WORD-1:0]   merged;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WORD-1:0]   fifo_out_data;
  logic [LVL_W-1:0]  fifo_level;

  ////////////////////////////////////////////////////////////////////////////
  wire k_rise     = k_phase == ddrb2_pkg::PHASE_K;
  wire kn_rise    = k_phase == ddrb2_pkg::PHASE_KN;
  wire cmd_valid  = k_rise && !load_n;                                 // RQ1 RQ2
  wire rd_accept  = cmd_valid && rw_sel == ddrb2_pkg::RW_READ && !cmd_stall; // RQ3 RQ19
  wire wr_accept  = cmd_valid && rw_sel != ddrb2_pkg::RW_READ;         // RQ8 RQ19
  wire wr_commit  = kn_rise && wr_go;                                  // RQ9 RQ13
  wire fetch      = k_rise && rd_pend;                                 // RQ23
  wire launch_ok  = oclk_tied_high || oclk_n_rise;                     // RQ17 RQ18
  wire pop        = kn_rise && out_state == ddrb2_pkg::OUT_IDLE && fifo_out_valid
                    && launch_ok;                                      // RQ5
  // Stall one entry early: a read already in flight still needs its slot.
  wire stall_next = fifo_level >= LVL_W'(ddrb2_pkg::FIFO_DEPTH - 1);

  // Lane merge: each nine-bit lane of each beat is kept or replaced on its own.
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      localparam int LO = l * ddrb2_pkg::LANE_W;
      assign merged[LO +: ddrb2_pkg::LANE_W] = beat0_mask_n[l] ?
          mem[wr_commit_addr][LO +: ddrb2_pkg::LANE_W] :
          beat0_data[LO +: ddrb2_pkg::LANE_W];                         // RQ11 RQ15 RQ16
      assign merged[DATA_W + LO +: ddrb2_pkg::LANE_W] = lane_mask_n[l] ?
          mem[wr_commit_addr][DATA_W + LO +: ddrb2_pkg::LANE_W] :
          write_bus[LO +: ddrb2_pkg::LANE_W];                          // RQ10 RQ12 RQ14
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      k_phase   <= ddrb2_pkg::PHASE_K;
      cmd_stall <= 1'b0;
      rd_pend   <= 1'b0;
      rd_addr   <= '0;
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
    end else begin
      k_phase   <= ~k_phase;
      cmd_stall <= stall_next;
      if (k_rise) begin
        rd_pend <= rd_accept;                                          // RQ2 RQ3
        wr_pend <= wr_accept;                                          // RQ2 RQ8
        if (rd_accept) rd_addr <= sync_addr_bus;
        if (wr_accept) wr_addr <= sync_addr_bus;
      end
    end
  end

  // Write data path: beat one on the true rise, beat two on the next complementary rise.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_go          <= 1'b0;
      wr_commit_addr <= '0;
      beat0_data     <= '0;
      beat0_mask_n   <= '1;
    end else if (k_rise) begin
      wr_go          <= wr_pend;                                       // RQ9
      wr_commit_addr <= wr_addr;
      beat0_data     <= write_bus;                                     // RQ9 RQ10
      beat0_mask_n   <= lane_mask_n;
    end else begin
      wr_go <= 1'b0;
    end
  end

  // Array without reset; a write commits half a cycle before any later fetch.
  always_ff @(posedge ref_clk) begin
    if (wr_commit) mem[wr_commit_addr] <= merged;                      // RQ13
  end

  ddrb2_fifo #(
    .WIDTH (WORD),
    .DEPTH (ddrb2_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (fetch),
    .in_ready  (fifo_in_ready),
    .in_data   (mem[rd_addr]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      out_state     <= ddrb2_pkg::OUT_IDLE;
      read_bus      <= '0;
      read_bus_oe_n <= ddrb2_pkg::OE_OFF_N;
      beat1_hold    <= '0;
    end else begin
      case (out_state)
        ddrb2_pkg::OUT_IDLE: begin
          if (pop) begin
            read_bus      <= fifo_out_data[DATA_W-1:0];                // RQ4 RQ5 RQ7
            beat1_hold    <= fifo_out_data[WORD-1:DATA_W];
            read_bus_oe_n <= ddrb2_pkg::OE_ON_N;
            out_state     <= ddrb2_pkg::OUT_SECOND;
          end else begin
            read_bus_oe_n <= ddrb2_pkg::OE_OFF_N;                      // RQ20 RQ22
          end
        end
        ddrb2_pkg::OUT_SECOND: begin
          read_bus  <= beat1_hold;                                     // RQ6 RQ7
          out_state <= ddrb2_pkg::OUT_IDLE;
        end
        default: begin
          out_state     <= ddrb2_pkg::OUT_IDLE;
          read_bus_oe_n <= ddrb2_pkg::OE_OFF_N;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  wire [ddrb2_pkg::LANE_W-1:0] lane0_b1_now = mem[wr_commit_addr][DATA_W +: ddrb2_pkg::LANE_W];
  wire [DATA_W-1:0]            fifo_beat1   = fifo_out_data[WORD-1:DATA_W];

  sequence s_read_cmd;
    k_rise && !load_n && rw_sel && !cmd_stall && oclk_tied_high && !fifo_out_valid
      && !rd_pend && out_state == ddrb2_pkg::OUT_IDLE;
  endsequence
  sequence s_two_beats;
    // A read issued one K cycle later keeps the bus driven, so only the two beats are required.
    !read_bus_oe_n [*2];
  endsequence

  property p_deselect;
    k_rise && load_n |=> !rd_pend && !wr_pend;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect started a command"); // RQ2

  property p_read_start;
    k_rise && !load_n && rw_sel && !cmd_stall |=> rd_pend && rd_addr == $past(sync_addr_bus);
  endproperty
  a_read_start: assert property (p_read_start) else $error("read not started"); // RQ3

  property p_write_start;
    k_rise && !load_n && !rw_sel |=> wr_pend ##2 wr_go ##1 !wr_go;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write beats mistimed"); // RQ9

  property p_read_latency;
    s_read_cmd |-> read_bus_oe_n [*4] ##1 s_two_beats;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read beats mistimed"); // RQ7

  property p_beat_pair;
    $fell(read_bus_oe_n) |=> !read_bus_oe_n && read_bus == $past(fifo_beat1, 2);
  endproperty
  a_beat_pair: assert property (p_beat_pair) else $error("second beat missing"); // RQ6

  property p_launch_edge;
    $fell(read_bus_oe_n) |-> k_phase == ddrb2_pkg::PHASE_K
      && ($past(oclk_tied_high) || $past(oclk_n_rise));
  endproperty
  a_launch_edge: assert property (p_launch_edge) else $error("launch on wrong edge"); // RQ5

  property p_idle_quiet;
    out_state == ddrb2_pkg::OUT_IDLE && !pop |=> read_bus_oe_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("read bus driven idle"); // RQ22

  property p_mask_keeps;
    wr_commit && lane_mask_n[0] |=> $past(lane0_b1_now) ==
      mem[$past(wr_commit_addr)][DATA_W +: ddrb2_pkg::LANE_W];
  endproperty
  a_mask_keeps: assert property (p_mask_keeps) else $error("masked lane changed"); // RQ11

  property p_fifo_room;
    fetch |-> fifo_in_ready;
  endproperty
  a_fifo_room: assert property (p_fifo_room) else $error("read fetch lost"); // RQ19
endmodule // ddrb2_sram_port

`default_nettype wire

// [bench/ddrb2_ctl_model.sv]
// Controller model that drives commands, write beats and the output clock level.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module ddrb2_ctl_model #(
  parameter int DW = 18,
  parameter int AW = 6
) (
  // Clock from the bench, phase from the RAM, slow-partner switch from the bench.
  input  wire logic       ref_clk,
  input  wire logic       k_phase,
  input  wire logic       slow,
  // Pins toward the RAM.
  output logic [AW-1:0]   sync_addr_bus,
  output logic            load_n,
  output logic            rw_sel,
  output logic [DW-1:0]   write_bus,
  output logic [DW/9-1:0] lane_mask_n,
  output logic            oclk_n_rise
);
  localparam int LN = DW / 9;
  int seed = 32'h84af;
  int cyc  = 0;
  int last = 0;
  int r;

  initial begin
    sync_addr_bus = '0;
    load_n        = 1'b1;
    rw_sel        = 1'b0;
    write_bus     = '0;
    lane_mask_n   = '1;
    oclk_n_rise   = 1'b1;
  end

  // A slow partner holds the output clock back on random cycles.
  always @(posedge ref_clk) begin
    cyc++;
    #1;
    r = $random(seed);
    oclk_n_rise = !slow || r[0];
  end

  // Commands wait out the lock interval, then for a true-clock edge.
  task automatic align();
    while (cyc < ddrb2_pkg::LOCK_CYCLES) @(posedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      #1;
      if (k_phase === 1'b0) break;
    end
  endtask

  task automatic cmd(input logic ld_n, rw, input logic [AW-1:0] a,
                     input logic [2*DW-1:0] d, input logic [2*LN-1:0] m);
    load_n        = ld_n;
    rw_sel        = rw;
    sync_addr_bus = a;
    @(posedge ref_clk);
    #1;
    load_n        = 1'b1;
    rw_sel        = ~rw;
    sync_addr_bus = ~a;
    if (!ld_n && !rw) begin
      last++;
      fork
        begin
          automatic int id = last;
          @(posedge ref_clk);
          #1;
          write_bus   = d[0+:DW];
          lane_mask_n = m[0+:LN];
          @(posedge ref_clk);
          #1;
          write_bus   = d[DW+:DW];
          lane_mask_n = m[LN+:LN];
          @(posedge ref_clk);
          #1;
          // Stale data is inverted so that a late capture cannot match by luck.
          if (id == last) write_bus = ~d[DW+:DW];
        end
      join_none
    end
  endtask
endmodule // ddrb2_ctl_model
`default_nettype wire

// [bench/ddrb2_sram_port_bench.sv]
// Self-checking bench for the burst-of-two RAM port.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module ddrb2_sram_port_bench;
  localparam int DW = 18;
  localparam int AW = 6;
  localparam int ML = 2 * DW / 9;
  logic              ref_clk;
  logic              rstn;
  logic              tied;
  logic              slow;
  logic              saw_stall = 1'b0;
  wire logic [AW-1:0]   addr;
  wire logic            load_n;
  wire logic            rw_sel;
  wire logic [DW-1:0]   wdata;
  wire logic [ML/2-1:0] mask_n;
  wire logic            oclk_n;
  logic [DW-1:0]     read_bus;
  logic              oe_n;
  logic              k_phase;
  logic              cmd_stall;
  logic [2*DW-1:0]   mem [2**AW];
  logic [DW-1:0]     expq [$];
  int                fails     = 0;
  int                cmp_count = 0;
  int                seed      = 32'h84af;
  int                n;

  ddrb2_ctl_model #(.DW(DW), .AW(AW)) ctl (
    .ref_clk(ref_clk), .k_phase(k_phase), .slow(slow), .sync_addr_bus(addr),
    .load_n(load_n), .rw_sel(rw_sel), .write_bus(wdata), .lane_mask_n(mask_n),
    .oclk_n_rise(oclk_n));

  ddrb2_sram_port #(.DATA_W(DW), .ADDR_W(AW)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .sync_addr_bus(addr), .load_n(load_n),
    .rw_sel(rw_sel), .write_bus(wdata), .lane_mask_n(mask_n),
    .oclk_tied_high(tied), .oclk_n_rise(oclk_n), .read_bus(read_bus),
    .read_bus_oe_n(oe_n), .k_phase(k_phase), .cmd_stall(cmd_stall));

  ////////////////////////////////////////
  function automatic logic [2*DW-1:0] rnd();
    logic [63:0] v;
    v = {$random(seed), $random(seed)};
    return v[2*DW-1:0];
  endfunction

  // Lanes run upward through the word {beat1, beat0}.
  function automatic logic [2*DW-1:0] merge(input logic [2*DW-1:0] o, d,
                                            input logic [ML-1:0] m);
    for (int l = 0; l < ML; l++) if (m[l] === 1'b0) o[9*l+:9] = d[9*l+:9];
    return o;
  endfunction

  task automatic chk(input logic [2*DW-1:0] got, input logic [2*DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input logic ld_n, rw, input logic [AW-1:0] a,
                    input logic [2*DW-1:0] d, input logic [ML-1:0] m);
    logic [2*DW-1:0] w;
    ctl.align();
    w = mem[a];
    if (!ld_n && rw && cmd_stall === 1'b0) begin
      expq.push_back(w[DW-1:0]);
      expq.push_back(w[2*DW-1:DW]);
    end
    if (!ld_n && !rw) mem[a] = merge(w, d, m);
    if (cmd_stall === 1'b1) saw_stall = 1'b1;
    ctl.cmd(ld_n, rw, a, d, m);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  always @(posedge ref_clk) begin
    #1;
    if (rstn && oe_n === 1'b0 && expq.size() > 0) chk(read_bus, expq.pop_front());
    else if (rstn) chk(oe_n, 1'b1);
  end

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    tied = 1'b1;
    slow = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    chk({read_bus, oe_n, k_phase, cmd_stall}, {{DW{1'b0}}, 3'b100});
    for (int a = 0; a < 2**AW; a++) op(1'b0, 1'b0, a[AW-1:0], rnd(), '0);
    op(1'b0, 1'b1, 6'h05, '0, '0);
    n = 0;
    while (oe_n !== 1'b0 && n < 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n, 3);
    for (int m = 0; m < 16; m++) begin
      n = $random(seed);
      op(1'b0, 1'b0, n[AW-1:0], rnd(), m[ML-1:0]);
      op(1'b0, 1'b1, n[AW-1:0], '0, '0);
    end
    tied = 1'b0;
    // A held-back output clock with a read every K cycle fills the FIFO until reads stall.
    slow = 1'b1;
    for (int p = 0; p < 32; p++) op(1'b0, 1'b1, p[AW-1:0], '0, '0);
    for (int p = 0; p < 400; p++) begin
      slow = p[8];
      n = $random(seed);
      op(n[0] & n[1], n[2], n[AW+7:8], rnd(), n[7:4]);
    end
    slow = 1'b0;
    n = 0;
    while (expq.size() > 0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk(expq.size(), 0);
    chk(saw_stall, 1'b1);
    repeat (4) @(posedge ref_clk);
    report_and_stop();
  end
endmodule // ddrb2_sram_port_bench
`default_nettype wire
